// [inc/pim_pkg.sv]
// Types shared by the pin interrupt engine and its synchroniser.
// Assumes nothing of its surroundings.
`default_nettype none
package pim_pkg;
	typedef logic [31:0] pim_word_t;
	typedef logic [7:0] pim_chan_t;
	typedef logic [11:0] pim_addr_t;
	typedef logic [95:0] pim_pins_t;
	typedef logic [55:0] pim_sel_t;
	// Condition tested by one pattern slice.
	typedef enum logic [2:0] {
		PIM_COND_ALWAYS = 3'h0,
		PIM_COND_ST_RISE = 3'h1,
		PIM_COND_ST_FALL = 3'h2,
		PIM_COND_ST_EDGE = 3'h3,
		PIM_COND_HIGH = 3'h4,
		PIM_COND_LOW = 3'h5,
		PIM_COND_NEVER = 3'h6,
		PIM_COND_EVENT = 3'h7
	} pim_cond_e;
endpackage : pim_pkg
`default_nettype wire

// [inc/pim_regs.svh]
// Register offsets, field positions, reset values and sizes of the pin interrupt engine.
// Assumes inclusion by bare name from a design file; holds definitions only.
`ifndef PIM_REGS_SVH
`define PIM_REGS_SVH

// Sizes of the engine.
`define PIM_CHANNELS 8
`define PIM_PIN_COUNT 96
`define PIM_SEL_W 7
`define PIM_SRC_W 3
`define PIM_COND_W 3
`define PIM_ADDR_W 12

// Pin indices that can never be routed into the engine.
`define PIM_PORT2_PIN8 7'h48
`define PIM_PORT2_PIN23 7'h57
`define PIM_PIN_LIMIT 7'h60

// Register offsets (byte addresses).
`define PIM_OFS_MODE 12'h000
`define PIM_OFS_RISE_EN 12'h004
`define PIM_OFS_FALL_EN 12'h008
`define PIM_OFS_RISE_DET 12'h00C
`define PIM_OFS_FALL_DET 12'h010
`define PIM_OFS_PIN_LEVEL 12'h014
`define PIM_OFS_PM_CTRL 12'h018
`define PIM_OFS_PM_SRC 12'h01C
`define PIM_OFS_PM_CFG 12'h020
`define PIM_OFS_INT_STAT 12'h024
`define PIM_OFS_INT_CLR 12'h028
`define PIM_OFS_INT_EN 12'h02C

// Field positions.
`define PIM_PM_CTRL_ENABLE 0
`define PIM_PM_CTRL_EVENT 1
`define PIM_PM_CFG_COND_LSB 8

// Reset values.
`define PIM_RST_BYTE 8'h00
`define PIM_RST_WORD 32'h00000000
`define PIM_RST_SRC 24'h000000
`define PIM_RST_CTRL 2'h0

`endif

// [logic/pim_engine.sv]
// Pin interrupt and pattern match engine with an APB register slave.
// Assumes pin selections come from the system configuration block and pins are asynchronous inputs.
// What this block does
// - Software routes up to eight digital pins into eight channels.
// - Pins port2_pin8 and port2_pin23 never reach any channel.
// - Pin choice per channel arrives from the system configuration block.
// - Each channel drives its own interrupt line.
// - Edge channels request on rising, falling or both edges.
// - Level channels are active high or active low.
// - Pin interrupt requests drive the wake-up output.
// - Pattern mode feeds the eight channels into one boolean expression.
// - Each slice tests a level or a transition on a chosen channel.
// - Each product term raises its own request line.
// - When enabled, any match pulses cpu_event_notify.
// - Pattern matches never wake the part.
// - Registers answer every access in a single cycle.
`timescale 1ns/1ps
`default_nettype none
`include "pim_regs.svh"
module pim_engine (
	// Clock and reset.
	input wire logic CLK_IN,
	input wire logic RESET_N_IN,
	// APB slave.
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire pim_pkg::pim_addr_t PADDR_IN,
	input wire pim_pkg::pim_word_t PWDATA_IN,
	output pim_pkg::pim_word_t PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	// Pins and their selection.
	input wire pim_pkg::pim_pins_t DIGITAL_PINS_IN,
	input wire pim_pkg::pim_sel_t PIN_SEL_IN,
	// Requests to the processor.
	output pim_pkg::pim_chan_t CHAN_IRQ_OUT,
	output logic IRQ_OUT,
	output logic WAKE_OUT,
	output logic CPU_EVENT_NOTIFY_OUT
);
	import pim_pkg::*;

	logic [1:0] rst_sync_reg;
	logic rst_n;
	pim_chan_t raw_pin, pin_level, pin_rise, pin_fall;
	pim_chan_t mode_reg, rise_en_reg, fall_en_reg, rise_det_reg, fall_det_reg;
	pim_chan_t int_stat_reg, int_en_reg, chan_irq_reg, term_prev_reg;
	pim_chan_t slice_rise_reg, slice_fall_reg;
	logic [1:0] pm_ctrl_reg;
	logic [23:0] pm_src_reg;
	pim_word_t pm_cfg_reg, prdata_reg;
	logic wake_reg, event_reg;
	pim_chan_t pin_req, slice_val, acc, endpt, term, chan_req;
	pim_chan_t rise_clr, fall_clr, int_clr;
	logic wr_en, rd_setup, mapped, cfg_wr, pm_en;

	////////////////////////////////////////////////////////////////////////////////
	// Reset release through two flops; the rest of the engine uses the copy.
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	////////////////////////////////////////////////////////////////////////////////
	// Per-channel pin routing and synchronisation.
	genvar gi;
	generate
		for (gi = 0; gi < `PIM_CHANNELS; gi = gi + 1) begin : g_chan
			logic [`PIM_SEL_W-1:0] sel;
			assign sel = PIN_SEL_IN[gi*`PIM_SEL_W +: `PIM_SEL_W];
			// Excluded or absent pins read as a constant low.
			assign raw_pin[gi] = (sel == `PIM_PORT2_PIN8 || sel == `PIM_PORT2_PIN23 ||
				sel >= `PIM_PIN_LIMIT) ? 1'b0 : DIGITAL_PINS_IN[sel];
			pim_sync u_sync (
				.clk_in(CLK_IN),
				.rst_n_in(rst_n),
				.pin_in(raw_pin[gi]),
				.level_out(pin_level[gi]),
				.rise_out(pin_rise[gi]),
				.fall_out(pin_fall[gi])
			);
			// Pin interrupt request: level follows the pin, edge follows the sticky flags.
			assign pin_req[gi] = mode_reg[gi] ?
				(rise_en_reg[gi] & (pin_level[gi] == fall_en_reg[gi])) :
				(rise_det_reg[gi] | fall_det_reg[gi]);

			// Pattern slice: source channel and condition.
			logic [`PIM_SRC_W-1:0] src;
			pim_cond_e cond;
			assign src = pm_src_reg[gi*`PIM_SRC_W +: `PIM_SRC_W];
			assign cond = pim_cond_e'(pm_cfg_reg[`PIM_PM_CFG_COND_LSB + gi*`PIM_COND_W +: `PIM_COND_W]);
			always_comb begin
				unique case (cond)
					PIM_COND_ALWAYS: slice_val[gi] = 1'b1;
					PIM_COND_ST_RISE: slice_val[gi] = slice_rise_reg[gi];
					PIM_COND_ST_FALL: slice_val[gi] = slice_fall_reg[gi];
					PIM_COND_ST_EDGE: slice_val[gi] = slice_rise_reg[gi] | slice_fall_reg[gi];
					PIM_COND_HIGH: slice_val[gi] = pin_level[src];
					PIM_COND_LOW: slice_val[gi] = ~pin_level[src];
					PIM_COND_NEVER: slice_val[gi] = 1'b0;
					PIM_COND_EVENT: slice_val[gi] = pin_rise[src] | pin_fall[src];
				endcase
			end
			// The last slice always closes a product term.
			assign endpt[gi] = (gi == `PIM_CHANNELS - 1) ? 1'b1 : pm_cfg_reg[gi];
			if (gi == 0) begin : g_first
				assign acc[gi] = slice_val[gi];
			end else begin : g_next
				assign acc[gi] = slice_val[gi] & (endpt[gi-1] | acc[gi-1]);
			end
			assign term[gi] = acc[gi] & endpt[gi];

			// Sticky slice transitions; a new edge wins over a configuration clear.
			always_ff @(posedge CLK_IN or negedge rst_n) begin
				if (!rst_n) begin
					slice_rise_reg[gi] <= 1'b0;
					slice_fall_reg[gi] <= 1'b0;
				end else begin
					slice_rise_reg[gi] <= (slice_rise_reg[gi] & ~cfg_wr) | pin_rise[src];
					slice_fall_reg[gi] <= (slice_fall_reg[gi] & ~cfg_wr) | pin_fall[src];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// APB decode; the slave never inserts wait states.
	assign pm_en = pm_ctrl_reg[`PIM_PM_CTRL_ENABLE];
	assign wr_en = PSEL_IN & PENABLE_IN & PWRITE_IN;
	assign rd_setup = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
	assign cfg_wr = wr_en & (PADDR_IN == `PIM_OFS_PM_CFG);
	assign PREADY_OUT = 1'b1;
	assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~mapped;
	assign rise_clr = (wr_en && PADDR_IN == `PIM_OFS_RISE_DET) ? PWDATA_IN[7:0] : `PIM_RST_BYTE;
	assign fall_clr = (wr_en && PADDR_IN == `PIM_OFS_FALL_DET) ? PWDATA_IN[7:0] : `PIM_RST_BYTE;
	assign int_clr = (wr_en && PADDR_IN == `PIM_OFS_INT_CLR) ? PWDATA_IN[7:0] : `PIM_RST_BYTE;

	// Address map check.
	always_comb begin
		unique case (PADDR_IN)
			`PIM_OFS_MODE, `PIM_OFS_RISE_EN, `PIM_OFS_FALL_EN, `PIM_OFS_RISE_DET,
			`PIM_OFS_FALL_DET, `PIM_OFS_PIN_LEVEL, `PIM_OFS_PM_CTRL, `PIM_OFS_PM_SRC,
			`PIM_OFS_PM_CFG, `PIM_OFS_INT_STAT, `PIM_OFS_INT_CLR, `PIM_OFS_INT_EN: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Software-written configuration registers.
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= `PIM_RST_BYTE;
			rise_en_reg <= `PIM_RST_BYTE;
			fall_en_reg <= `PIM_RST_BYTE;
			int_en_reg <= `PIM_RST_BYTE;
			pm_ctrl_reg <= `PIM_RST_CTRL;
			pm_src_reg <= `PIM_RST_SRC;
			pm_cfg_reg <= `PIM_RST_WORD;
		end else if (wr_en) begin
			unique case (PADDR_IN)
				`PIM_OFS_MODE: mode_reg <= PWDATA_IN[7:0];
				`PIM_OFS_RISE_EN: rise_en_reg <= PWDATA_IN[7:0];
				`PIM_OFS_FALL_EN: fall_en_reg <= PWDATA_IN[7:0];
				`PIM_OFS_INT_EN: int_en_reg <= PWDATA_IN[7:0];
				`PIM_OFS_PM_CTRL: pm_ctrl_reg <= PWDATA_IN[1:0];
				`PIM_OFS_PM_SRC: pm_src_reg <= PWDATA_IN[23:0];
				`PIM_OFS_PM_CFG: pm_cfg_reg <= PWDATA_IN;
				default: ;
			endcase
		end
	end

	// Read data is captured in the setup cycle so it stands during the access cycle.
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			prdata_reg <= `PIM_RST_WORD;
		end else if (rd_setup) begin
			unique case (PADDR_IN)
				`PIM_OFS_MODE: prdata_reg <= {24'h000000, mode_reg};
				`PIM_OFS_RISE_EN: prdata_reg <= {24'h000000, rise_en_reg};
				`PIM_OFS_FALL_EN: prdata_reg <= {24'h000000, fall_en_reg};
				`PIM_OFS_RISE_DET: prdata_reg <= {24'h000000, rise_det_reg};
				`PIM_OFS_FALL_DET: prdata_reg <= {24'h000000, fall_det_reg};
				`PIM_OFS_PIN_LEVEL: prdata_reg <= {24'h000000, pin_level};
				`PIM_OFS_PM_CTRL: prdata_reg <= {30'h0, pm_ctrl_reg};
				`PIM_OFS_PM_SRC: prdata_reg <= {8'h00, pm_src_reg};
				`PIM_OFS_PM_CFG: prdata_reg <= pm_cfg_reg;
				`PIM_OFS_INT_STAT: prdata_reg <= {24'h000000, int_stat_reg};
				`PIM_OFS_INT_EN: prdata_reg <= {24'h000000, int_en_reg};
				default: prdata_reg <= `PIM_RST_WORD;
			endcase
		end
	end
	assign PRDATA_OUT = prdata_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Sticky edge flags of edge channels; a new edge wins over a write-one clear.
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			rise_det_reg <= `PIM_RST_BYTE;
			fall_det_reg <= `PIM_RST_BYTE;
		end else begin
			rise_det_reg <= (rise_det_reg & ~rise_clr) | (pin_rise & rise_en_reg & ~mode_reg);
			fall_det_reg <= (fall_det_reg & ~fall_clr) | (pin_fall & fall_en_reg & ~mode_reg);
		end
	end

	// Request selection: pin interrupts or product terms share the channel lines.
	assign chan_req = pm_en ? term : pin_req;

	// Channel lines, wake-up and event notification.
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			chan_irq_reg <= `PIM_RST_BYTE;
			wake_reg <= 1'b0;
			term_prev_reg <= `PIM_RST_BYTE;
			event_reg <= 1'b0;
		end else begin
			chan_irq_reg <= chan_req;
			wake_reg <= ~pm_en & (|pin_req);
			term_prev_reg <= term;
			event_reg <= pm_en & pm_ctrl_reg[`PIM_PM_CTRL_EVENT] & (|(term & ~term_prev_reg));
		end
	end
	assign CHAN_IRQ_OUT = chan_irq_reg;
	assign WAKE_OUT = wake_reg;
	assign CPU_EVENT_NOTIFY_OUT = event_reg;

	// Summary status: set by any channel request, cleared by write-one, set wins.
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			int_stat_reg <= `PIM_RST_BYTE;
		end else begin
			int_stat_reg <= (int_stat_reg & ~int_clr) | chan_req;
		end
	end
	assign IRQ_OUT = |(int_stat_reg & int_en_reg);

	////////////////////////////////////////////////////////////////////////////////
	// Checks on the engine's behaviour.
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!rst_n);

	a_single_cycle_ready: assert property (
		PSEL_IN && !PENABLE_IN |=> PREADY_OUT && !(PENABLE_IN && !PREADY_OUT))
		else $error("Access did not complete in one cycle.");
	a_excluded_pin_low: assert property (
		(PIN_SEL_IN[3*`PIM_SEL_W +: `PIM_SEL_W] == `PIM_PORT2_PIN8 ||
		PIN_SEL_IN[3*`PIM_SEL_W +: `PIM_SEL_W] == `PIM_PORT2_PIN23) |-> !raw_pin[3])
		else $error("Excluded pin reached channel 3.");
	a_excluded_pin_ch4: assert property (
		(PIN_SEL_IN[4*`PIM_SEL_W +: `PIM_SEL_W] == `PIM_PORT2_PIN8 ||
		PIN_SEL_IN[4*`PIM_SEL_W +: `PIM_SEL_W] == `PIM_PORT2_PIN23) |-> !raw_pin[4])
		else $error("Excluded pin reached channel 4.");
	a_rise_edge_flag: assert property (
		|(pin_rise & rise_en_reg & ~mode_reg) |=> |(rise_det_reg & ~mode_reg))
		else $error("Enabled rising edge did not set its flag.");
	a_fall_edge_flag: assert property (
		pin_fall[0] && fall_en_reg[0] && !mode_reg[0] |=> fall_det_reg[0])
		else $error("Enabled falling edge did not set its flag.");
	a_edge_request: assert property (
		!pm_en && !mode_reg[1] && (rise_det_reg[1] || fall_det_reg[1]) |=> CHAN_IRQ_OUT[1])
		else $error("Pending edge flag did not raise channel 1.");
	a_level_active: assert property (
		!pm_en && mode_reg[2] && rise_en_reg[2] && pin_level[2] == fall_en_reg[2] |=> CHAN_IRQ_OUT[2])
		else $error("Active level did not raise channel 2.");
	a_level_drop: assert property (
		!pm_en && mode_reg[2] && pin_level[2] != fall_en_reg[2] |=> !CHAN_IRQ_OUT[2])
		else $error("Level request stayed up after the pin left its level.");
	a_term_request: assert property (
		pm_en |=> CHAN_IRQ_OUT == $past(term))
		else $error("Channel lines do not follow the product terms.");
	a_pin_wake: assert property (
		!pm_en && (|pin_req) |=> WAKE_OUT)
		else $error("Pin request did not wake the part.");
	a_no_match_wake: assert property (
		pm_en |=> !WAKE_OUT)
		else $error("Pattern mode drove the wake-up output.");
	a_event_gated: assert property (
		!pm_ctrl_reg[`PIM_PM_CTRL_EVENT] |=> !CPU_EVENT_NOTIFY_OUT)
		else $error("Event sent while notification is disabled.");
	a_event_on_match: assert property (
		pm_en && pm_ctrl_reg[`PIM_PM_CTRL_EVENT] && (|(term & ~term_prev_reg)) |=> CPU_EVENT_NOTIFY_OUT)
		else $error("New match did not pulse the event output.");
	a_event_pulse: assert property (
		CPU_EVENT_NOTIFY_OUT && !(pm_en && pm_ctrl_reg[`PIM_PM_CTRL_EVENT] && (|(term & ~term_prev_reg))) |=> !CPU_EVENT_NOTIFY_OUT)
		else $error("Event output stayed up without a new match.");
	a_status_sticky: assert property (
		int_stat_reg[0] && int_clr[0] == 1'b0 |=> int_stat_reg[0])
		else $error("Status bit lost without a clear.");
	a_status_set: assert property (
		|chan_req |=> (int_stat_reg & $past(chan_req)) == $past(chan_req))
		else $error("Channel request did not set its status bit.");
	a_status_clear: assert property (
		int_stat_reg[0] && int_clr[0] && !chan_req[0] |=> !int_stat_reg[0])
		else $error("Write-one clear did not clear the status bit.");
endmodule : pim_engine
`default_nettype wire

// [logic/pim_sync.sv]
// Synchroniser and edge detector for one selected pin.
// Assumes a clock and an active-low reset already released synchronously.
`timescale 1ns/1ps
`default_nettype none
module pim_sync (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Pin and results.
	input wire logic pin_in,
	output logic level_out,
	output logic rise_out,
	output logic fall_out
);
	import pim_pkg::*;

	logic meta_reg;
	logic level_reg;
	logic prev_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Two flops bring the pin into the clock domain; a third keeps the last sample.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_reg <= 1'b0;
			level_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			meta_reg <= pin_in;
			level_reg <= meta_reg;
			prev_reg <= level_reg;
		end
	end

	// Edges come from comparing the current sample with the previous one.
	assign level_out = level_reg;
	assign rise_out = level_reg & ~prev_reg;
	assign fall_out = ~level_reg & prev_reg;

	a_edge_compare: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(level_out) |-> rise_out && !fall_out)
		else $error("Rising sample not flagged as a rising edge.");
	a_fall_compare: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$fell(level_out) |-> fall_out && !rise_out)
		else $error("Falling sample not flagged as a falling edge.");
endmodule : pim_sync
`default_nettype wire

// [verification/pim_cpu_model.sv]
// Model of the processor side of the engine: request lines and the event input.
// Assumes the engine's clock and its raw active-low reset.
`timescale 1ns/1ps
`default_nettype none
module pim_cpu_model (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Requests from the engine.
	input wire logic [7:0] irq_lines_in,
	input wire logic event_in,
	// What the processor saw.
	output var int events_out,
	output logic [7:0] seen_out
);
	// Count event cycles and note every request line that was ever raised.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			events_out <= 0;
			seen_out <= 8'h00;
		end else begin
			events_out <= events_out + int'(event_in);
			seen_out <= seen_out | irq_lines_in;
		end
	end
endmodule : pim_cpu_model
`default_nettype wire

// [verification/tb_pin_interrupt_pattern_match.sv]
// Self-checking bench for the pin interrupt engine: APB tasks and pin stimulus.
// Assumes pim_engine, pim_cpu_model, pim_pkg and pim_regs.svh.
`timescale 1ns/1ps
`default_nettype none
`include "pim_regs.svh"
module tb_pin_interrupt_pattern_match;
	import pim_pkg::*;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, wake, irq, evt, e, r;
	pim_addr_t paddr;
	pim_word_t pwdata, prdata, obs, q;
	pim_pins_t pins;
	pim_sel_t sel;
	pim_chan_t chan, seen;
	int failures, num_checks, events;
	////////////////////////////////////////////////////////////////////////////
	pim_engine dut_u (.CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
		.PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .DIGITAL_PINS_IN(pins), .PIN_SEL_IN(sel),
		.CHAN_IRQ_OUT(chan), .IRQ_OUT(irq), .WAKE_OUT(wake), .CPU_EVENT_NOTIFY_OUT(evt));
	pim_cpu_model cpu_u (.clk_in(clk), .rst_n_in(rst_n), .irq_lines_in(chan), .event_in(evt),
		.events_out(events), .seen_out(seen));
	// Outputs gathered into one word: wake, summary request, channel lines.
	assign obs = {22'h0, wake, irq, chan};
	// Free-running 50 MHz clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////////
	// Count a comparison and report a mismatch at once.
	task automatic chk(input pim_word_t got, input pim_word_t exp, input string what);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	// Print the counts and the verdict, then stop.
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : test_done
	// One APB transfer, entered and left just after a rising edge; a hang ends the run.
	task automatic apb(input logic wr, input pim_addr_t a, input pim_word_t d);
		int n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			r = pready;
			q = prdata;
			e = pslverr;
			n++;
		end while (r !== 1'b1 && n < 16);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk); // An idle edge keeps the next call from raising psel in the step that lowered it.
		chk(32'(n), 32'h1, "access length");
		if (r !== 1'b1) begin
			test_done();
		end
	endtask : apb
	task automatic wr(input pim_addr_t a, input pim_word_t d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input pim_addr_t a, input pim_word_t exp, input string what);
		apb(1'b0, a, 32'h0);
		chk(q, exp, what);
	endtask : rd
	// Let a pin change or a setting pass the synchroniser and the request flop.
	task automatic wt();
		repeat (6) @(posedge clk);
	endtask : wt
	task automatic pin(input int idx, input logic v);
		pins[idx] <= v;
		wt();
	endtask : pin
	// Compare the output word where it is settled, then return to the rising edge.
	task automatic ochk(input pim_word_t exp, input string what);
		@(negedge clk);
		chk(obs, exp, what);
		@(posedge clk);
	endtask : ochk
	task automatic do_reset();
		rst_n <= 1'b0;
		pins <= '0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
	endtask : do_reset
	////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset, edge channels, level channel, pattern match.
	initial begin
		{psel, penable, pwrite, paddr, pwdata, rst_n} = '0;
		pins = '0;
		failures = 0;
		num_checks = 0;
		sel = {7'h02, 7'h01, 7'h5F, `PIM_PORT2_PIN23, `PIM_PORT2_PIN8, 7'h28, 7'h06, 7'h05};
		do_reset();
		for (int a = 0; a < 12; a++) begin
			rd(pim_addr_t'(4 * a), 32'h0, "reset value");
		end
		rd(12'h030, 32'h0, "unmapped read");
		chk(32'(e), 32'h1, "unmapped error");
		ochk(32'h0, "idle outputs");
		$display("Test reset done");
		// Rising edge on channel 0, sticky status, mask and clear.
		wr(`PIM_OFS_INT_EN, 32'hFF);
		wr(`PIM_OFS_RISE_EN, 32'h39);
		pin(5, 1'b1);
		ochk(32'h301, "rise request");
		rd(`PIM_OFS_RISE_DET, 32'h1, "rise flag");
		rd(`PIM_OFS_PIN_LEVEL, 32'h1, "levels");
		pin(5, 1'b0);
		rd(`PIM_OFS_FALL_DET, 32'h0, "fall ignored");
		wr(`PIM_OFS_RISE_DET, 32'h1);
		ochk(32'h100, "status held");
		wr(`PIM_OFS_INT_EN, 32'h0);
		ochk(32'h0, "masked");
		wr(`PIM_OFS_INT_CLR, 32'h1);
		rd(`PIM_OFS_INT_STAT, 32'h0, "cleared");
		pin(`PIM_PORT2_PIN8, 1'b1);
		pin(`PIM_PORT2_PIN23, 1'b1);
		pin(95, 1'b1);
		ochk(32'h220, "pin routing");
		rd(`PIM_OFS_INT_STAT, 32'h20, "own line");
		$display("Test rising edge done");
		// Falling, then both edges on channel 1.
		do_reset();
		wr(`PIM_OFS_INT_EN, 32'hFF);
		wr(`PIM_OFS_FALL_EN, 32'h2);
		pin(6, 1'b1);
		ochk(32'h0, "rise ignored");
		for (int i = 0; i < 3; i++) begin
			if (i == 1) begin
				wr(`PIM_OFS_RISE_EN, 32'h2);
			end
			pin(6, i[0]);
			ochk(32'h302, "edge request");
			wr(`PIM_OFS_RISE_DET, 32'h2);
			wr(`PIM_OFS_FALL_DET, 32'h2);
			wr(`PIM_OFS_INT_CLR, 32'h2);
			ochk(32'h0, "edge cleared");
		end
		$display("Test falling edge done");
		// Level channel 2, active high and then active low.
		do_reset();
		wr(`PIM_OFS_INT_EN, 32'hFF);
		wr(`PIM_OFS_MODE, 32'h4);
		wr(`PIM_OFS_FALL_EN, 32'h4);
		wr(`PIM_OFS_RISE_EN, 32'h4);
		ochk(32'h0, "low idle");
		pin(40, 1'b1);
		ochk(32'h304, "high active");
		pin(40, 1'b0);
		ochk(32'h100, "level left");
		wr(`PIM_OFS_FALL_EN, 32'h0);
		wt();
		ochk(32'h304, "low active");
		pin(40, 1'b1);
		ochk(32'h100, "low left");
		rd(`PIM_OFS_RISE_DET, 32'h0, "no edge flag");
		$display("Test level done");
		// One product term: channel 0 high and a rise on channel 1.
		do_reset();
		wr(`PIM_OFS_INT_EN, 32'hFF);
		wr(`PIM_OFS_PM_SRC, 32'h08);
		wr(`PIM_OFS_PM_CFG, 32'hC0000C02);
		wr(`PIM_OFS_PM_CTRL, 32'h3);
		pin(5, 1'b1);
		ochk(32'h0, "half term");
		pin(6, 1'b1);
		ochk(32'h102, "term match, no wake");
		chk(32'(events), 32'h1, "event pulse");
		pin(5, 1'b0);
		ochk(32'h100, "term broken");
		wr(`PIM_OFS_PM_CTRL, 32'h1);
		wr(`PIM_OFS_PM_CFG, 32'hC0000C02);
		pin(5, 1'b1);
		pin(6, 1'b0);
		ochk(32'h100, "sticky cleared");
		pin(6, 1'b1);
		ochk(32'h102, "term again");
		chk(32'(events), 32'h1, "event off");
		chk(32'(seen), 32'h2, "lines seen");
		$display("Test pattern done");
		test_done();
	end
endmodule : tb_pin_interrupt_pattern_match
`default_nettype wire
